/* rtl/host_bus_defs.svh */
// Offsets, field positions, reset values and timing counts of the host pin logic
`ifndef HOST_BUS_DEFS_SVH
`define HOST_BUS_DEFS_SVH
`define CLK_PERIOD_NS 25
`define RST_FILTER_NS 100
`define RST_FILTER_CYCLES ((`RST_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFS_CONFIG 6'h00
`define OFS_BASE 6'h04
`define OFS_IRQ_STATUS 6'h08
`define OFS_IRQ_MASK 6'h0c
`define OFS_CARD 6'h10
`define OFS_DATA_BIT 5
`define CFG_MODE_LSB 0
`define CFG_SEL_LSB 2
`define CFG_WIDE_BIT 4
`define CFG_HIRQ_BIT 5
`define CFG_RESET 6'h10
`define BASE_RESET 12'h030
`define EV_HOST_WRITE 0
`define EV_HOST_READ 1
`define EV_HOST_RESET 2
`define EV_CARD_OPT 3
`define EV_COUNT 4
`define CARD_STATUS_LSB 8
`endif

/* rtl/host_bus_pkg.sv */
// Types shared by the host pin logic
package host_bus_pkg;
  typedef enum logic [1:0] {
    mode_local_type_v = 2'h0,
    mode_card_type_v = 2'h1,
    mode_strobe_type_v = 2'h2
  } bus_mode_type;
endpackage

/* rtl/reset_glitch_filter.sv */
// Glitch filter for the active-high host reset pin
`timescale 1ns/1ps
`default_nettype none
`include "host_bus_defs.svh"
module reset_glitch_filter #(
  parameter int unsigned MIN_CYCLES = `RST_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Raw pin and filtered result
  input wire logic raw_reset,
  output logic filtered_ff
);
  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic nxt_filtered;

  // Count consecutive high samples; any low sample restarts the count
  always_comb begin
    nxt_count = 8'h00;
    nxt_filtered = 1'b0;
    if (raw_reset) begin
      nxt_count = (count_ff == MIN_CYCLES[7:0]) ? count_ff : count_ff + 8'h01;
      nxt_filtered = (count_ff >= MIN_CYCLES[7:0] - 8'h01); // [R01]
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_ff <= 8'h00;
      filtered_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      filtered_ff <= nxt_filtered;
    end
  end
endmodule
`default_nettype wire

/* rtl/host_bus_pin_logic.sv */
// Host bus pin logic: local, card and strobe bus personalities with Avalon control
// Overview of operation
// R01 - Reset pin ignored unless high 100ns
// R02 - Sixteen bit two-way register data bus
// R03 - Strobe mode: board swaps the byte lanes
// R04 - Local: strobe falling edge latches address
// R05 - Card: write enable writes option/status registers
// R06 - Local: one selected interrupt line, others tri-stated
// R07 - Card: active-low interrupt request output
// R08 - Strobe mode: software selects interrupt line zero; the code drives whichever line irq_line_select names
// R09 - Card: acknowledge each addressed read cycle
// R10 - Local: wide select on base match
// R11 - Card: wide indication when enabled and selected
// R12 - Host drives read strobe low to read
// R13 - Strobe mode: any data strobe qualifies transfer
// R14 - Local: decode only while qualifier low
// R15 - Card: host asserts attribute/io select
// R16 - Strobe mode: host sets transfer direction
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "host_bus_defs.svh"
module host_bus_pin_logic #(
  parameter int unsigned MIN_RST_CYCLES = `RST_FILTER_CYCLES,
  parameter int unsigned DATA_WORDS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata_ff,
  output logic avs_waitrequest_ff,
  // Interrupt to the local processor
  output logic irq_ff,
  // Host control pins
  input wire logic host_reset,
  input wire logic [15:0] host_addr,
  input wire logic high_byte_enable_n,
  input wire logic addr_latch_strobe,
  input wire logic addr_qualifier,
  input wire logic io_read_n,
  input wire logic io_write_n,
  // Host data bus
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out_ff,
  output logic host_data_oe_ff,
  // Interrupt and acknowledge pins
  output logic [3:0] irq_line_out_ff,
  output logic [3:0] irq_line_oe_ff,
  // Open-drain wide cycle pin, driven low when enabled
  output logic wide_io_out_ff,
  output logic wide_io_oe_ff
);
  // Shared pins take their other names in the other personalities
  logic card_write_enable;
  logic attr_io_select_n;
  logic data_strobe_in;
  logic read_not_write;
  logic pin_rst_ff;
  logic rst;
  assign card_write_enable = addr_latch_strobe;
  assign attr_io_select_n = addr_qualifier;
  assign data_strobe_in = io_read_n;
  assign read_not_write = io_write_n;

  // Filtered host reset clears the pin side; the Avalon side keeps its state
  reset_glitch_filter #(
    .MIN_CYCLES(MIN_RST_CYCLES)
  ) u_rst_filter (
    .clk(clk),
    .sys_rst(sys_rst),
    .raw_reset(host_reset),
    .filtered_ff(pin_rst_ff)
  );
  assign rst = sys_rst | pin_rst_ff;

  // Matches an Avalon word offset
  function automatic logic avl_hit(input logic [5:0] addr, input logic [5:0] ofs);
    avl_hit = (addr[5:2] == ofs[5:2]);
  endfunction

  // Avalon-side registers
  logic [5:0] cfg_ff;
  logic [5:0] nxt_cfg;
  logic [11:0] base_ff;
  logic [11:0] nxt_base;
  logic [`EV_COUNT-1:0] status_ff;
  logic [`EV_COUNT-1:0] nxt_status;
  logic [`EV_COUNT-1:0] mask_ff;
  logic [`EV_COUNT-1:0] nxt_mask;
  logic [31:0] nxt_readdata;
  logic nxt_waitrequest;
  logic nxt_irq;
  logic [`EV_COUNT-1:0] events;
  logic pin_rst_prev_ff;

  // Pin-side state
  logic [15:0] addr_lat_ff;
  logic [15:0] nxt_addr_lat;
  logic hbe_lat_ff;
  logic nxt_hbe_lat;
  logic rd_prev_ff;
  logic wr_prev_ff;
  logic cwe_prev_ff;
  logic rd_act_prev_ff;
  logic [7:0] card_option_reg_ff;
  logic [7:0] card_status_reg_ff;
  logic [7:0] nxt_card_option_reg;
  logic [7:0] nxt_card_status_reg;
  logic [15:0] mem_ff [DATA_WORDS];
  logic [15:0] nxt_mem [DATA_WORDS];

  // Decoded pin state
  host_bus_pkg::bus_mode_type mode;
  logic [1:0] irq_line_select;
  logic wide_mode;
  logic host_irq;
  logic card_enable_bit;
  logic [15:0] eff_addr;
  logic eff_hbe_n;
  logic local_sel;
  logic card_sel;
  logic rd_act;
  logic wr_done;
  logic attr_wr;
  logic [2:0] word_idx;
  logic lane_lo;
  logic lane_hi;
  logic avl_ack;

  assign mode = host_bus_pkg::bus_mode_type'(cfg_ff[`CFG_MODE_LSB +: 2]);
  assign irq_line_select = cfg_ff[`CFG_SEL_LSB +: 2];
  assign wide_mode = cfg_ff[`CFG_WIDE_BIT];
  assign host_irq = cfg_ff[`CFG_HIRQ_BIT];
  assign card_enable_bit = card_option_reg_ff[0];
  assign avl_ack = (avs_read | avs_write) & ~avs_waitrequest_ff;

  // Address selection and strobe decoding for the active personality
  always_comb begin
    nxt_addr_lat = addr_latch_strobe ? host_addr : addr_lat_ff; // [R04]
    nxt_hbe_lat = addr_latch_strobe ? high_byte_enable_n : hbe_lat_ff; // [R04]
    eff_addr = host_addr;
    eff_hbe_n = high_byte_enable_n;
    if (mode == host_bus_pkg::mode_local_type_v) begin
      eff_addr = addr_lat_ff;
      eff_hbe_n = hbe_lat_ff;
    end
    // Qualifier high means a DMA cycle; the device must stay deaf to it
    local_sel = ~addr_qualifier && (eff_addr[15:4] == base_ff); // [R14] [R10]
    card_sel = ~attr_io_select_n && card_enable_bit; // [R15]
    rd_act = 1'b0;
    wr_done = 1'b0;
    attr_wr = 1'b0;
    lane_lo = ~eff_addr[0];
    lane_hi = ~eff_hbe_n | eff_addr[0];
    unique case (mode)
      host_bus_pkg::mode_local_type_v: begin
        rd_act = local_sel & ~io_read_n; // [R12]
        wr_done = local_sel & io_write_n & ~wr_prev_ff;
      end
      host_bus_pkg::mode_card_type_v: begin
        rd_act = card_sel & ~io_read_n; // [R12]
        wr_done = card_sel & io_write_n & ~wr_prev_ff;
        attr_wr = ~attr_io_select_n & card_write_enable & ~cwe_prev_ff; // [R05]
      end
      host_bus_pkg::mode_strobe_type_v: begin
        // Strobe low qualifies; direction taken at the strobe
        rd_act = ~data_strobe_in & read_not_write; // [R13] [R16]
        wr_done = data_strobe_in & ~rd_prev_ff & ~wr_prev_ff; // [R13] [R16]
        lane_lo = 1'b1;
        lane_hi = 1'b1;
      end
      default: begin
        rd_act = 1'b0;
      end
    endcase
    word_idx = eff_addr[3:1];
  end

  // Pin-side edge and address latch registers
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_lat_ff <= 16'h0000;
      hbe_lat_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
      wr_prev_ff <= 1'b1;
      cwe_prev_ff <= 1'b1;
      rd_act_prev_ff <= 1'b0;
    end else begin
      addr_lat_ff <= nxt_addr_lat;
      hbe_lat_ff <= nxt_hbe_lat;
      rd_prev_ff <= io_read_n;
      wr_prev_ff <= io_write_n;
      cwe_prev_ff <= card_write_enable;
      rd_act_prev_ff <= rd_act;
    end
  end

  // Data words: host pin writes take priority over Avalon writes
  always_comb begin
    for (int i = 0; i < DATA_WORDS; i++) begin
      nxt_mem[i] = mem_ff[i];
    end
    if (avl_ack && avs_write && avs_address[`OFS_DATA_BIT]) begin
      nxt_mem[avs_address[4:2]] = avs_writedata[15:0];
    end
    if (wr_done) begin
      if (lane_lo) begin
        nxt_mem[word_idx][7:0] = host_data_in[7:0]; // [R02]
      end
      if (lane_hi) begin
        nxt_mem[word_idx][15:8] = host_data_in[15:8]; // [R02]
      end
    end
    nxt_card_option_reg = card_option_reg_ff;
    nxt_card_status_reg = card_status_reg_ff;
    if (attr_wr && !eff_addr[1]) begin
      nxt_card_option_reg = host_data_in[7:0]; // [R05]
    end
    if (attr_wr && eff_addr[1]) begin
      nxt_card_status_reg = host_data_in[7:0]; // [R05]
    end
  end

  // Data word and card register storage
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DATA_WORDS; i++) begin
        mem_ff[i] <= 16'h0000;
      end
      card_option_reg_ff <= 8'h00;
      card_status_reg_ff <= 8'h00;
    end else begin
      for (int i = 0; i < DATA_WORDS; i++) begin
        mem_ff[i] <= nxt_mem[i];
      end
      card_option_reg_ff <= nxt_card_option_reg;
      card_status_reg_ff <= nxt_card_status_reg;
    end
  end

  // Avalon slave: one wait state, status cleared by the accepted read
  always_comb begin
    events = '0;
    events[`EV_HOST_WRITE] = wr_done | attr_wr;
    events[`EV_HOST_READ] = rd_act & ~rd_act_prev_ff;
    events[`EV_HOST_RESET] = pin_rst_ff & ~pin_rst_prev_ff;
    events[`EV_CARD_OPT] = attr_wr;
    nxt_cfg = cfg_ff;
    nxt_base = base_ff;
    nxt_mask = mask_ff;
    nxt_status = status_ff;
    if (avl_ack && avs_write) begin
      if (avl_hit(avs_address, `OFS_CONFIG)) begin
        nxt_cfg = avs_writedata[5:0];
      end
      if (avl_hit(avs_address, `OFS_BASE)) begin
        nxt_base = avs_writedata[11:0];
      end
      if (avl_hit(avs_address, `OFS_IRQ_MASK)) begin
        nxt_mask = avs_writedata[`EV_COUNT-1:0];
      end
    end
    if (avl_ack && avs_read && avl_hit(avs_address, `OFS_IRQ_STATUS)) begin
      nxt_status = status_ff & ~avs_readdata_ff[`EV_COUNT-1:0]; // Only reported bits
    end
    // Set wins: an event during the read's wait or clearing cycle survives
    nxt_status = nxt_status | events;
    nxt_readdata = 32'h0000_0000;
    if (avs_address[`OFS_DATA_BIT]) begin
      nxt_readdata = {16'h0000, mem_ff[avs_address[4:2]]};
    end else if (avl_hit(avs_address, `OFS_CONFIG)) begin
      nxt_readdata = {26'h0000000, cfg_ff};
    end else if (avl_hit(avs_address, `OFS_BASE)) begin
      nxt_readdata = {20'h00000, base_ff};
    end else if (avl_hit(avs_address, `OFS_IRQ_STATUS)) begin
      nxt_readdata = {28'h0000000, status_ff};
    end else if (avl_hit(avs_address, `OFS_IRQ_MASK)) begin
      nxt_readdata = {28'h0000000, mask_ff};
    end else if (avl_hit(avs_address, `OFS_CARD)) begin
      nxt_readdata = {16'h0000, card_status_reg_ff, card_option_reg_ff};
    end
    nxt_waitrequest = ~((avs_read | avs_write) & avs_waitrequest_ff);
    nxt_irq = |(nxt_status & nxt_mask);
  end

  // Avalon-side registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_ff <= `CFG_RESET;
      base_ff <= `BASE_RESET;
      status_ff <= '0;
      mask_ff <= '0;
      avs_readdata_ff <= 32'h0000_0000;
      avs_waitrequest_ff <= 1'b1;
      irq_ff <= 1'b0;
      pin_rst_prev_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      base_ff <= nxt_base;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      avs_readdata_ff <= nxt_readdata;
      avs_waitrequest_ff <= nxt_waitrequest;
      irq_ff <= nxt_irq;
      pin_rst_prev_ff <= pin_rst_ff;
    end
  end

  // Host-facing pin drivers
  logic [15:0] nxt_data_out;
  logic nxt_data_oe;
  logic [3:0] nxt_line_out;
  logic [3:0] nxt_line_oe;
  logic nxt_wide_oe;
  // Next pin values for the active personality
  always_comb begin
    nxt_data_out = mem_ff[word_idx]; // [R02]
    nxt_data_oe = rd_act; // [R02]
    nxt_wide_oe = 1'b0;
    for (int i = 0; i < 4; i++) begin
      // In local and strobe modes only the selected line drives; the rest float for other cards
      nxt_line_out[i] = host_irq; // [R06] [R08]
      nxt_line_oe[i] = (irq_line_select == i[1:0]); // [R06] [R08]
    end
    unique case (mode)
      host_bus_pkg::mode_local_type_v: begin
        nxt_wide_oe = wide_mode & local_sel; // [R10]
      end
      host_bus_pkg::mode_card_type_v: begin
        nxt_wide_oe = wide_mode & card_enable_bit & ~attr_io_select_n; // [R11]
        nxt_line_out[0] = ~host_irq; // [R07]
        nxt_line_oe[0] = 1'b1;
        nxt_line_out[1] = ~rd_act; // [R09]
        nxt_line_oe[1] = 1'b1;
        nxt_line_oe[2] = 1'b0;
        nxt_line_oe[3] = 1'b0;
      end
      host_bus_pkg::mode_strobe_type_v: begin
        nxt_wide_oe = 1'b0;
      end
      default: begin
        nxt_wide_oe = 1'b0;
      end
    endcase
  end

  // Pin output registers
  always_ff @(posedge clk) begin
    if (rst) begin
      host_data_out_ff <= 16'h0000;
      host_data_oe_ff <= 1'b0;
      irq_line_out_ff <= 4'h0;
      irq_line_oe_ff <= 4'h0;
      wide_io_out_ff <= 1'b0;
      wide_io_oe_ff <= 1'b0;
    end else begin
      host_data_out_ff <= nxt_data_out;
      host_data_oe_ff <= nxt_data_oe;
      irq_line_out_ff <= nxt_line_out;
      irq_line_oe_ff <= nxt_line_oe;
      wide_io_out_ff <= 1'b0;
      wide_io_oe_ff <= nxt_wide_oe;
    end
  end
endmodule
`default_nettype wire

/* test/host_bus_props.sv */
// Concurrent checks on the host bus pin logic ports
`timescale 1ns/1ps
`default_nettype none
module host_bus_props #(
  parameter int unsigned MIN_RST_CYCLES = 4,
  parameter int unsigned DATA_WORDS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon side
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata_ff,
  input wire logic avs_waitrequest_ff,
  input wire logic irq_ff,
  // Host pins
  input wire logic host_reset,
  input wire logic [15:0] host_addr,
  input wire logic high_byte_enable_n,
  input wire logic addr_latch_strobe,
  input wire logic addr_qualifier,
  input wire logic io_read_n,
  input wire logic io_write_n,
  input wire logic [15:0] host_data_in,
  input wire logic [15:0] host_data_out_ff,
  input wire logic host_data_oe_ff,
  input wire logic [3:0] irq_line_out_ff,
  input wire logic [3:0] irq_line_oe_ff,
  input wire logic wide_io_out_ff,
  input wire logic wide_io_oe_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Run of high host reset samples; saturates so a long reset never wraps
  logic [3:0] hr_cnt_ff;
  logic [3:0] nxt_hr_cnt;
  always_comb begin
    nxt_hr_cnt = hr_cnt_ff;
    if (!host_reset) nxt_hr_cnt = 4'h0;
    else if (hr_cnt_ff != 4'hf) nxt_hr_cnt = hr_cnt_ff + 4'h1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) hr_cnt_ff <= 4'h0;
    else hr_cnt_ff <= nxt_hr_cnt;
  end
  // Bus handshake, pin drivers and filtered pin reset
  chk_ack_single: assert property (!avs_waitrequest_ff |=> avs_waitrequest_ff)
    else $error("ack held longer than one cycle");
  chk_ack_cause: assert property (!avs_waitrequest_ff |-> $past(avs_read || avs_write))
    else $error("ack without request");
  chk_ack_latency: assert property ((avs_read || avs_write) && avs_waitrequest_ff
    && !$past(avs_read || avs_write) |=> !avs_waitrequest_ff) else $error("ack late");
  chk_irq_tristate: assert property (|irq_line_oe_ff[3:2] |-> $onehot(irq_line_oe_ff))
    else $error("more than one interrupt line driven");
  chk_wide_drain: assert property (wide_io_oe_ff |-> !wide_io_out_ff)
    else $error("wide pin driven high");
  chk_wide_qual: assert property (wide_io_oe_ff |-> $past(!addr_qualifier))
    else $error("wide pin without qualifier low");
  chk_data_cause: assert property (host_data_oe_ff |-> $past(!io_read_n))
    else $error("data bus driven without read strobe");
  chk_reset_quiet: assert property ($fell(sys_rst) |-> avs_waitrequest_ff && !irq_ff
    && irq_line_oe_ff == 4'h0 && !host_data_oe_ff) else $error("outputs active after reset");
  chk_pin_reset: assert property (hr_cnt_ff > MIN_RST_CYCLES |-> ##1
    (!host_data_oe_ff && !wide_io_oe_ff)) else $error("pin reset did not quiet pins");
  cov_read_ack: cover property (!avs_waitrequest_ff && avs_read);
  cov_irq: cover property (irq_ff);
  cov_wide_read: cover property (wide_io_oe_ff && host_data_oe_ff);
endmodule
`default_nettype wire

/* test/host_model.sv */
// Host processor model driving the local, card and strobe pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Device pins seen by the host
  input wire logic [15:0] dout,
  input wire logic doe,
  input wire logic wide,
  input wire logic ack_n,
  // Host driven pins
  output logic [15:0] addr,
  output logic hbe_n,
  output logic als,
  output logic aq,
  output logic rd_n,
  output logic wr_n,
  output logic [15:0] din
);
  // Idle: strobes high, released data at its pull-up level
  initial begin
    addr = 16'hffff;
    hbe_n = 1'b1;
    als = 1'b1;
    aq = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    din = 16'hffff;
  end
  // One I/O cycle; lb pulses the address strobe, then scrambles the live address
  task automatic io(input logic lb, input logic w, input logic q, input logic [15:0] a,
                    input logic [15:0] d, output logic [15:0] r, output logic [2:0] s);
    @(posedge clk);
    addr <= a;
    hbe_n <= 1'b0;
    @(posedge clk);
    als <= !lb; // Card write enable stays idle outside local mode
    aq <= q;
    rd_n <= w;
    wr_n <= !w;
    din <= w ? d : 16'hffff;
    @(posedge clk);
    if (lb) addr <= ~a; // Only the latched copy may decode
    repeat (2) @(posedge clk);
    r = dout;
    s = {doe, wide, ack_n};
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    @(posedge clk);
    aq <= 1'b1; // Qualifier outlasts the write strobe so the write still decodes
    als <= 1'b1;
    din <= 16'hffff;
    hbe_n <= 1'b1;
    @(posedge clk);
  endtask
  // Attribute write: byte stored on the rising write enable
  task automatic attr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    aq <= 1'b0;
    din <= {8'hff, d};
    als <= 1'b0;
    repeat (2) @(posedge clk);
    als <= 1'b1;
    @(posedge clk);
    aq <= 1'b1;
    din <= 16'hffff;
    @(posedge clk);
  endtask
  // Strobe-mode write: direction set first, then the data strobe pulses low
  task automatic strobe_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_n <= 1'b0;
    din <= {d[7:0], d[15:8]}; // Board crosses the byte lanes
    @(posedge clk);
    rd_n <= 1'b0;
    repeat (2) @(posedge clk);
    rd_n <= 1'b1;
    @(posedge clk);
    wr_n <= 1'b1;
    din <= 16'hffff;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the host bus pin logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic host_reset = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata_ff;
  logic avs_waitrequest_ff, irq_ff, hbe_n, als, aq, rd_n, wr_n, doe, wide_out, wide_oe;
  logic [15:0] host_addr, din, dout;
  logic [3:0] line_out, line_oe;
  int err_total = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  host_bus_pin_logic #(.MIN_RST_CYCLES(4), .DATA_WORDS(8)) dut (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata_ff(avs_readdata_ff),
    .avs_waitrequest_ff(avs_waitrequest_ff), .irq_ff(irq_ff), .host_reset(host_reset),
    .host_addr(host_addr), .high_byte_enable_n(hbe_n), .addr_latch_strobe(als),
    .addr_qualifier(aq), .io_read_n(rd_n), .io_write_n(wr_n), .host_data_in(din),
    .host_data_out_ff(dout), .host_data_oe_ff(doe), .irq_line_out_ff(line_out),
    .irq_line_oe_ff(line_oe), .wide_io_out_ff(wide_out), .wide_io_oe_ff(wide_oe));
  host_model host (.clk(clk), .dout(dout), .doe(doe), .wide(wide_oe), .ack_n(line_out[1]),
    .addr(host_addr), .hbe_n(hbe_n), .als(als), .aq(aq), .rd_n(rd_n), .wr_n(wr_n), .din(din));
  // Waits for the ack edge; bounded so a stuck slave cannot hang the run
  task automatic av_wait();
    int n = 0;
    @(posedge clk);
    while (avs_waitrequest_ff !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) err_total++;
  endtask
  task automatic av_wr(input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    av_wait();
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic av_rd(input logic [5:0] a, output logic [31:0] r);
    avs_address <= a;
    avs_read <= 1'b1;
    av_wait();
    r = avs_readdata_ff;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_regs();
    logic [31:0] v;
    av_rd(6'h00, v);
    `CHK(v, 32'h10);
    av_rd(6'h04, v);
    `CHK(v, 32'h30);
    av_rd(6'h14, v);
    `CHK(v, 32'h0);
  endtask
  // Every line select, then strobe and card personalities
  task automatic t_irq();
    for (int i = 0; i < 4; i++) begin
      av_wr(6'h00, 32'h30 | (32'(i) << 2));
      repeat (3) @(posedge clk);
      `CHK(line_oe, 4'h1 << i);
      `CHK(line_out[i], 1'b1);
    end
    av_wr(6'h00, 32'h32);
    repeat (3) @(posedge clk);
    `CHK({line_oe, line_out[0]}, 5'h03);
    av_wr(6'h00, 32'h31);
    repeat (3) @(posedge clk);
    `CHK({line_oe, line_out[1:0]}, 6'h0e);
  endtask
  task automatic t_local();
    logic [15:0] r;
    logic [2:0] s;
    logic [31:0] v;
    av_wr(6'h00, 32'h10);
    av_wr(6'h20, 32'habcd);
    host.io(1'b1, 1'b0, 1'b0, 16'h0300, 16'h0, r, s);
    `CHK({r, s[2:1]}, 18'h2af37);
    host.io(1'b1, 1'b0, 1'b1, 16'h0300, 16'h0, r, s);
    `CHK(s[2:1], 2'b00);
    host.io(1'b1, 1'b0, 1'b0, 16'h0400, 16'h0, r, s);
    `CHK(s[2:1], 2'b00);
    av_wr(6'h0c, 32'h1);
    host.io(1'b1, 1'b1, 1'b0, 16'h0302, 16'h1234, r, s);
    repeat (2) @(posedge clk);
    `CHK(irq_ff, 1'b1);
    av_rd(6'h24, v);
    `CHK(v, 32'h1234);
    av_rd(6'h08, v);
    `CHK(v, 32'h3);
    repeat (2) @(posedge clk);
    `CHK(irq_ff, 1'b0);
  endtask
  task automatic t_card();
    logic [15:0] r;
    logic [2:0] s;
    logic [31:0] v;
    av_wr(6'h00, 32'h11);
    host.io(1'b0, 1'b0, 1'b0, 16'h0000, 16'h0, r, s);
    `CHK(s[1], 1'b0);
    host.attr(16'h0000, 8'h01);
    host.attr(16'h0002, 8'h5a);
    av_rd(6'h10, v);
    `CHK(v[15:0], 16'h5a01);
    av_rd(6'h08, v);
    `CHK(v[3], 1'b1);
    host.io(1'b0, 1'b0, 1'b0, 16'h0000, 16'h0, r, s);
    `CHK({r, s}, 19'h55e6e);
    av_wr(6'h00, 32'h12);
    host.io(1'b0, 1'b0, 1'b0, 16'h0300, 16'h0, r, s);
    `CHK({r, s[2]}, 17'h1579b);
    host.strobe_wr(16'h0304, 16'h1234);
    av_rd(6'h28, v);
    `CHK(v, 32'h3412);
  endtask
  // Short pin pulse is ignored, a long one resets the pin side
  task automatic t_hreset();
    logic [31:0] v;
    host_reset <= 1'b1;
    repeat (3) @(posedge clk);
    host_reset <= 1'b0;
    av_rd(6'h08, v);
    `CHK(v[2], 1'b0);
    host_reset <= 1'b1;
    repeat (5) @(posedge clk);
    host_reset <= 1'b0;
    repeat (3) @(posedge clk);
    av_rd(6'h08, v);
    `CHK(v[2], 1'b1);
    av_rd(6'h20, v);
    `CHK(v, 32'h0);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_irq();
    t_local();
    t_card();
    t_hreset();
    results();
  end
  // Watchdog sized well above the under two hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    results();
  end
endmodule
bind host_bus_pin_logic host_bus_props #(.MIN_RST_CYCLES(MIN_RST_CYCLES),
  .DATA_WORDS(DATA_WORDS)) props (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata_ff(avs_readdata_ff), .avs_waitrequest_ff(avs_waitrequest_ff),
  .irq_ff(irq_ff), .host_reset(host_reset), .host_addr(host_addr),
  .high_byte_enable_n(high_byte_enable_n), .addr_latch_strobe(addr_latch_strobe),
  .addr_qualifier(addr_qualifier), .io_read_n(io_read_n), .io_write_n(io_write_n),
  .host_data_in(host_data_in), .host_data_out_ff(host_data_out_ff),
  .host_data_oe_ff(host_data_oe_ff), .irq_line_out_ff(irq_line_out_ff),
  .irq_line_oe_ff(irq_line_oe_ff), .wide_io_out_ff(wide_io_out_ff),
  .wide_io_oe_ff(wide_io_oe_ff));
`default_nettype wire
